// ---- hdl/jfa_flash_access.sv ----
// JTAG indirect flash access engine with debug-halt controls
`timescale 1ns/1ps
module jfa_flash_access (
  // System clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // JTAG data register link, test clock domain
  input  wire logic               tck,
  input  wire logic [1:0]         drSel,
  input  wire logic               captureDr,
  input  wire logic               shiftDr,
  input  wire logic               updateDr,
  input  wire logic               tdi,
  output logic                    tdo,
  // Flash macro port
  output logic                    flashReq,
  output jfa_pkg::jfa_flash_t     flashOp,
  input  wire logic               flashAck,
  input  wire logic [7:0]         flashRdata,
  input  wire logic               flashFail,
  // Debug control
  input  wire logic               coreHalted,
  output logic                    wdtStop,
  output logic                    periphRun
);

  typedef enum logic {ST_IDLE, ST_FLASH} jfa_state_t;

  logic [2:0]                  rstT_ff;
  logic                        linkRst;
  logic [jfa_pkg::SR_W-1:0]    shift_ff;
  logic                        busy_ff;
  logic                        reqTgl_ff;
  jfa_pkg::jfa_req_t           req_ff;
  logic [2:0]                  doneS_ff;
  logic                        doneEdge;
  logic [jfa_pkg::WD_W-1:0]    rdHold_ff;
  logic [1:0]                  opCode;
  logic [2:0]                  reqS_ff;
  logic                        reqEdge;
  jfa_state_t                  state_ff;
  logic                        doneTgl_ff;
  logic                        flashReq_ff;
  jfa_pkg::jfa_flash_t         flashOp_ff;
  logic [7:0]                  ctrl_ff;
  logic [15:0]                 addr_ff;
  logic [7:0]                  byte_ff;
  logic                        fail_ff;
  logic                        unread_ff;
  logic [jfa_pkg::WD_W-1:0]    resp_ff;
  logic                        wdtStop_ff;
  logic                        periphRun_ff;
  logic                        decode;
  logic                        wrReq;
  logic                        rdReq;
  logic [7:0]                  wrByte;
  logic [2:0]                  wrMode;
  logic [3:0]                  rdMode;
  logic                        startProg;
  logic                        startErase;
  logic                        startRead;
  logic                        ack;

  // True for the addresses that widen an erase to all user space
  function automatic logic eraseAll(input logic [15:0] a);
    eraseAll = (a == jfa_pkg::ERASE_ALL_LO) || (a == jfa_pkg::ERASE_ALL_HI);
  endfunction

  // Reset brought into the test clock domain
  always_ff @(posedge tck) begin
    rstT_ff <= {rstT_ff[1:0], rst};
  end
  assign linkRst = rstT_ff[1] | rstT_ff[2];

  // Done toggle from the engine, synchronised
  always_ff @(posedge tck) begin
    if (linkRst) begin
      doneS_ff <= 3'h0;
    end else begin
      doneS_ff <= {doneS_ff[1:0], doneTgl_ff};
    end
  end
  assign doneEdge = doneS_ff[1] ^ doneS_ff[2];
  assign opCode   = shift_ff[jfa_pkg::OP_MSB:jfa_pkg::OP_LSB];

  // Data register: capture status, shift LSB first
  always_ff @(posedge tck) begin
    if (linkRst) begin
      shift_ff <= '0;
    end else if (captureDr) begin
      // busy at bit 0, read data above it
      shift_ff <= {1'b0, rdHold_ff, busy_ff};
    end else if (shiftDr) begin
      shift_ff <= {tdi, shift_ff[jfa_pkg::SR_W-1:1]};
    end
  end
  assign tdo = shift_ff[0];

  // Command issue and busy tracking
  always_ff @(posedge tck) begin
    if (linkRst) begin
      busy_ff   <= 1'b0;
      reqTgl_ff <= 1'b0;
      req_ff    <= '0;
      rdHold_ff <= '0;
    end else if (doneEdge) begin
      busy_ff   <= 1'b0;
      rdHold_ff <= resp_ff; // Held stable by the engine until next request
    end else if (updateDr && !busy_ff && opCode[1]) begin
      // read and write taken only while idle
      busy_ff   <= 1'b1;
      reqTgl_ff <= ~reqTgl_ff;
      req_ff    <= '{sel: drSel, isWrite: opCode == jfa_pkg::OP_WRITE,
                     wdata: shift_ff[jfa_pkg::WD_W-1:0]};
    end
  end

  // Request toggle into the system domain
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reqS_ff <= 3'h0;
    end else begin
      reqS_ff <= {reqS_ff[1:0], reqTgl_ff};
    end
  end
  assign reqEdge = reqS_ff[1] ^ reqS_ff[2];

  // Request decode
  always_comb begin
    decode     = (state_ff == ST_IDLE) && reqEdge;
    wrReq      = decode && req_ff.isWrite;
    rdReq      = decode && !req_ff.isWrite;
    wrByte     = req_ff.wdata[jfa_pkg::WD_W-1:jfa_pkg::WB_LSB];
    wrMode     = ctrl_ff[jfa_pkg::WM_MSB:jfa_pkg::WM_LSB];
    rdMode     = ctrl_ff[jfa_pkg::RM_MSB:jfa_pkg::RM_LSB];
    startProg  = wrReq && (req_ff.sel == jfa_pkg::SEL_DATA)
                 && (wrMode == jfa_pkg::WM_PROG);
    // erase only with the key byte
    startErase = wrReq && (req_ff.sel == jfa_pkg::SEL_DATA)
                 && (wrMode == jfa_pkg::WM_ERASE)
                 && (wrByte == jfa_pkg::ERASE_KEY);
    // block reads always, single reads when none unread
    startRead  = rdReq && (req_ff.sel == jfa_pkg::SEL_DATA)
                 && ((rdMode == jfa_pkg::RM_BLOCK)
                 || ((rdMode == jfa_pkg::RM_SINGLE) && !unread_ff));
    ack        = (state_ff == ST_FLASH) && flashAck;
  end

  // Engine sequencing and flash requests
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff    <= ST_IDLE;
      doneTgl_ff  <= 1'b0;
      flashReq_ff <= 1'b0;
      flashOp_ff  <= '{cmd: jfa_pkg::FC_READ, addr: '0, wdata: '0};
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (startProg || startErase || startRead) begin
            state_ff    <= ST_FLASH;
            flashReq_ff <= 1'b1;
            flashOp_ff.addr  <= addr_ff;
            flashOp_ff.wdata <= wrByte;
            if (startProg) begin
              flashOp_ff.cmd <= jfa_pkg::FC_PROG;
            end else if (startRead) begin
              flashOp_ff.cmd <= jfa_pkg::FC_READ;
            end else if (eraseAll(addr_ff)) begin
              flashOp_ff.cmd <= jfa_pkg::FC_ERASE_USER;
            end else begin
              // erase the page holding the address
              flashOp_ff.cmd <= jfa_pkg::FC_ERASE_PAGE;
            end
          end else if (decode) begin
            doneTgl_ff <= ~doneTgl_ff;
          end
        end
        ST_FLASH: begin
          if (flashAck) begin
            state_ff    <= ST_IDLE;
            flashReq_ff <= 1'b0;
            doneTgl_ff  <= ~doneTgl_ff;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  assign flashReq = flashReq_ff;
  assign flashOp  = flashOp_ff;

  // Mode control and target address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_ff <= jfa_pkg::CTRL_RST;
      addr_ff <= jfa_pkg::ADDR_RST;
    end else if (wrReq && req_ff.sel == jfa_pkg::SEL_CTRL) begin
      ctrl_ff <= wrByte;
    end else if (wrReq && req_ff.sel == jfa_pkg::SEL_ADDR) begin
      addr_ff <= req_ff.wdata[jfa_pkg::WD_W-1:jfa_pkg::WA_LSB];
    end else if (ack && flashOp_ff.cmd == jfa_pkg::FC_PROG) begin
      // step the address once programming completes
      addr_ff <= addr_ff + 16'h0001;
    end
  end

  // Data window byte, fail flag and unread tracking
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      byte_ff   <= jfa_pkg::BYTE_RST;
      fail_ff   <= 1'b0;
      unread_ff <= 1'b0;
    end else if (ack) begin
      fail_ff <= flashFail;
      if (flashOp_ff.cmd == jfa_pkg::FC_READ) begin
        byte_ff   <= flashRdata;
        unread_ff <= 1'b1;
      end
    end else if (wrReq && req_ff.sel == jfa_pkg::SEL_DATA) begin
      byte_ff <= wrByte;
      if (startProg || startErase) begin
        fail_ff <= 1'b0;
      end
    end else if (rdReq && req_ff.sel == jfa_pkg::SEL_DATA) begin
      unread_ff <= 1'b0;
      if (startRead) begin
        fail_ff <= 1'b0;
      end
    end
  end

  // Read data captured before any new operation, right-justified
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resp_ff <= '0;
    end else if (rdReq) begin
      if (req_ff.sel == jfa_pkg::SEL_CTRL) begin
        resp_ff <= {10'h000, ctrl_ff};
      end else if (req_ff.sel == jfa_pkg::SEL_ADDR) begin
        resp_ff <= {2'h0, addr_ff};
      end else if (req_ff.sel == jfa_pkg::SEL_DATA) begin
        resp_ff <= {8'h00, byte_ff, fail_ff, state_ff == ST_FLASH};
      end else begin
        resp_ff <= '0;
      end
    end
  end

  // Debug halt: watchdog frozen, peripherals free running
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wdtStop_ff   <= 1'b0;
      periphRun_ff <= 1'b0;
    end else begin
      wdtStop_ff   <= coreHalted;
      periphRun_ff <= 1'b1;
    end
  end
  assign wdtStop   = wdtStop_ff;
  assign periphRun = periphRun_ff;

  a_busy_ignore: assert property (@(posedge tck) disable iff (linkRst)
    busy_ff && !doneEdge |=> $stable(reqTgl_ff) && $stable(req_ff))
    else $error("command taken while busy");
  a_erase_key: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(flashReq_ff) && (flashOp_ff.cmd == jfa_pkg::FC_ERASE_PAGE
    || flashOp_ff.cmd == jfa_pkg::FC_ERASE_USER)
    |-> flashOp_ff.wdata == jfa_pkg::ERASE_KEY)
    else $error("erase without key");
  a_erase_all: assert property (@(posedge sys_clk) disable iff (rst)
    startErase |=> flashOp_ff.cmd == (eraseAll($past(addr_ff)) ?
    jfa_pkg::FC_ERASE_USER : jfa_pkg::FC_ERASE_PAGE))
    else $error("wrong erase kind");
  a_erase_addr: assert property (@(posedge sys_clk) disable iff (rst)
    ack && flashOp_ff.cmd != jfa_pkg::FC_PROG |=> $stable(addr_ff))
    else $error("address moved by erase or read");
  a_prog_incr: assert property (@(posedge sys_clk) disable iff (rst)
    ack && flashOp_ff.cmd == jfa_pkg::FC_PROG
    |=> addr_ff == $past(addr_ff) + 16'h0001)
    else $error("address not stepped after program");
  a_plain_read: assert property (@(posedge sys_clk) disable iff (rst)
    rdReq && rdMode == jfa_pkg::RM_PLAIN |=> state_ff == ST_IDLE)
    else $error("plain mode read started flash");
  a_single_read: assert property (@(posedge sys_clk) disable iff (rst)
    rdReq && req_ff.sel == jfa_pkg::SEL_DATA
    && rdMode == jfa_pkg::RM_SINGLE |=> flashReq_ff == !$past(unread_ff))
    else $error("single read start wrong");
  a_done_once: assert property (@(posedge sys_clk) disable iff (rst)
    ack |=> !flashReq_ff && doneTgl_ff != $past(doneTgl_ff)
    && fail_ff == $past(flashFail))
    else $error("completion not reported");
  a_wdt_stop: assert property (@(posedge sys_clk) disable iff (rst)
    coreHalted |=> wdtStop_ff && periphRun_ff)
    else $error("watchdog not stopped on halt");
endmodule

// ---- include/jfa_pkg.sv ----
// Constants and types for the JTAG flash access block
package jfa_pkg;
  // Indirect command layout
  localparam int OP_MSB = 19;
  localparam int OP_LSB = 18;
  localparam int WD_W   = 18;
  localparam int SR_W   = 20;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h3;
  // Indirect register selects
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_ADDR = 2'h1;
  localparam logic [1:0] SEL_DATA = 2'h2;
  // Mode control fields
  localparam int WM_MSB = 6;
  localparam int WM_LSB = 4;
  localparam int RM_MSB = 3;
  localparam int RM_LSB = 0;
  localparam logic [2:0] WM_KEEP  = 3'h0;
  localparam logic [2:0] WM_PROG  = 3'h1;
  localparam logic [2:0] WM_ERASE = 3'h2;
  localparam logic [3:0] RM_PLAIN  = 4'h0;
  localparam logic [3:0] RM_BLOCK  = 4'h1;
  localparam logic [3:0] RM_SINGLE = 4'h2;
  // Erase key and whole-user-space trigger addresses
  localparam logic [7:0]  ERASE_KEY    = 8'ha5;
  localparam logic [15:0] ERASE_ALL_LO = 16'h7dfe;
  localparam logic [15:0] ERASE_ALL_HI = 16'h7dff;
  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  // Left-justified write data positions
  localparam int WB_LSB = 10;
  localparam int WA_LSB = 2;
  // Flash macro commands
  typedef enum logic [1:0] {
    FC_READ, FC_PROG, FC_ERASE_PAGE, FC_ERASE_USER
  } jfa_fcmd_t;
  // Request handed from the link to the engine
  typedef struct packed {
    logic [1:0]      sel;
    logic            isWrite;
    logic [WD_W-1:0] wdata;
  } jfa_req_t;
  // Operation presented to the flash macro
  typedef struct packed {
    jfa_fcmd_t   cmd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } jfa_flash_t;
endpackage

// ---- verification/jfa_flash_access_tb_top.sv ----
// Testbench for the JTAG flash access block
`timescale 1ns/1ps
module jfa_flash_access_tb_top;
  localparam logic [1:0] C = jfa_pkg::SEL_CTRL;
  localparam logic [1:0] A = jfa_pkg::SEL_ADDR;
  localparam logic [1:0] D = jfa_pkg::SEL_DATA;
  logic sys_clk, rst, tck, captureDr, shiftDr, updateDr, tdi, tdo;
  logic flashReq, flashAck, flashFail, coreHalted, wdtStop, periphRun;
  logic [1:0]          drSel;
  logic [7:0]          flashRdata;
  logic [9:0]          lat;
  logic [19:0]         so;
  logic [17:0]         rv;
  jfa_pkg::jfa_flash_t flashOp, lastOp;
  int                  nOps, n_fail, num_checks, n0;
  logic [15:0]         ta;
  jfa_pkg::jfa_fcmd_t  cx;
  // Design and flash macro
  jfa_flash_access i_dut (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .tck        (tck),
    .drSel      (drSel),
    .captureDr  (captureDr),
    .shiftDr    (shiftDr),
    .updateDr   (updateDr),
    .tdi        (tdi),
    .tdo        (tdo),
    .flashReq   (flashReq),
    .flashOp    (flashOp),
    .flashAck   (flashAck),
    .flashRdata (flashRdata),
    .flashFail  (flashFail),
    .coreHalted (coreHalted),
    .wdtStop    (wdtStop),
    .periphRun  (periphRun)
  );
  jfa_flash_model i_flash (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .flashReq   (flashReq),
    .flashOp    (flashOp),
    .flashAck   (flashAck),
    .flashRdata (flashRdata),
    .flashFail  (flashFail),
    .lat        (lat),
    .nOps       (nOps),
    .lastOp     (lastOp)
  );
  // Clocks
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    tck = 1'b0;
    #7;
    forever #15 tck = ~tck;
  end
  // Compares and counts
  task automatic chk(input logic [17:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Verdict
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Capture, 20 shifts LSB first, update
  task automatic scan(input logic [1:0] op, input logic [17:0] d);
    logic [19:0] v;
    v = {op, d};
    @(posedge tck) captureDr <= 1'b1;
    @(posedge tck) captureDr <= 1'b0;
    shiftDr <= 1'b1;
    tdi <= v[0];
    for (int i = 0; i < 20; i++) begin
      @(negedge tck) so[i] = tdo;
      @(posedge tck) tdi <= v[(i + 1) % 20];
      shiftDr <= (i < 19);
      updateDr <= (i == 19);
    end
    @(posedge tck) updateDr <= 1'b0;
  endtask
  // Polls busy with bounded tries; last capture holds read data
  task automatic idle();
    int k;
    k = 0;
    do begin
      scan(2'h0, 18'h0);
      k++;
    end while (so[0] !== 1'b0 && k < 200);
    rv = so[18:1];
    if (so[0] !== 1'b0) begin
      n_fail++;
      $display("Error at %0t: busy stuck", $time);
      conclude();
    end
  endtask
  // Register select changes only while idle
  task automatic acc(input logic [1:0] s, op, input logic [17:0] d);
    @(posedge tck) drSel <= s;
    scan(op, d);
    idle();
  endtask
  task automatic wr(input logic [1:0] s, input logic [17:0] d);
    acc(s, jfa_pkg::OP_WRITE, d);
  endtask
  task automatic rd(input logic [1:0] s);
    acc(s, jfa_pkg::OP_READ, 18'h0);
  endtask
  // Main sequence
  initial begin
    {rst, drSel, captureDr, shiftDr, updateDr, tdi} = 7'h40;
    coreHalted = 1'b0;
    lat = 10'd2;
    n_fail = 0;
    num_checks = 0;
    repeat (4) @(posedge sys_clk);
    repeat (3) @(posedge tck);
    @(posedge sys_clk) rst <= 1'b0;
    repeat (4) @(posedge tck);
    rd(C);
    chk(rv, 18'h0, "ctrl reset");
    rd(D);
    chk(rv, 18'h0, "data reset");
    rd(2'h3);
    chk(rv, 18'h0, "unmapped");
    $display("Test reset done");
    wr(C, 18'h04000);
    wr(A, {16'h1234, 2'h0});
    n0 = nOps;
    wr(D, {8'h3c, 10'h0});
    chk(18'(nOps - n0), 18'h1, "prog count");
    cx = jfa_pkg::FC_PROG;
    chk({lastOp.cmd, lastOp.addr}, {cx, 16'h1234}, "pa");
    chk(18'(lastOp.wdata), 18'h3c, "prog byte");
    rd(A);
    chk(rv, 18'h1235, "addr inc");
    $display("Test program done");
    wr(C, 18'h00400);
    wr(D, {8'h77, 10'h0});
    wr(A, {16'h1234, 2'h0});
    n0 = nOps;
    rd(D);
    chk(rv, 18'h1dc, "old window");
    rd(D);
    chk(rv, 18'h0f0, "block byte");
    chk(18'(nOps - n0), 18'h2, "block count");
    wr(C, 18'h00800);
    n0 = nOps;
    repeat (3) rd(D);
    chk(18'(nOps - n0), 18'h1, "single count");
    wr(C, 18'h0);
    n0 = nOps;
    rd(D);
    chk(18'(nOps - n0), 18'h0, "plain count");
    $display("Test read modes done");
    wr(C, 18'h08000);
    for (int i = 0; i < 3; i++) begin
      ta = (i == 0) ? 16'h0200 :
           ((i == 1) ? jfa_pkg::ERASE_ALL_LO : jfa_pkg::ERASE_ALL_HI);
      cx = (i == 0) ? jfa_pkg::FC_ERASE_PAGE : jfa_pkg::FC_ERASE_USER;
      wr(A, {ta, 2'h0});
      n0 = nOps;
      wr(D, {8'h5a, 10'h0});
      chk(18'(nOps - n0), 18'h0, "bad key");
      wr(D, {jfa_pkg::ERASE_KEY, 10'h0});
      chk(18'(nOps - n0), 18'h1, "erase count");
      chk({lastOp.cmd, lastOp.addr}, {cx, ta}, "er");
      rd(A);
      chk(rv, {2'h0, ta}, "addr kept");
    end
    $display("Test erase done");
    wr(C, 18'h04000);
    wr(A, {16'h0bad, 2'h0});
    wr(D, {8'h11, 10'h0});
    wr(C, 18'h0);
    rd(D);
    chk(rv, 18'h046, "fail flag");
    @(posedge sys_clk) lat <= 10'd300;
    wr(C, 18'h04000);
    wr(A, {16'h0300, 2'h0});
    @(posedge tck) drSel <= D;
    n0 = nOps;
    scan(jfa_pkg::OP_WRITE, {8'h22, 10'h0});
    scan(jfa_pkg::OP_WRITE, {8'h99, 10'h0});
    idle();
    chk(18'(nOps - n0), 18'h1, "busy refuse");
    chk(18'(lastOp.wdata), 18'h22, "first kept");
    @(posedge sys_clk) lat <= 10'd2;
    $display("Test fail and busy done");
    @(posedge sys_clk) coreHalted <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(18'(wdtStop), 18'h1, "wdt stop");
    chk(18'(periphRun), 18'h1, "periph run");
    @(posedge sys_clk) coreHalted <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(18'(wdtStop), 18'h0, "wdt run");
    $display("Test debug done");
    conclude();
  end
endmodule

// ---- verification/jfa_flash_model.sv ----
// Behavioural flash macro that answers the access engine
`timescale 1ns/1ps
module jfa_flash_model (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Macro handshake
  input  wire logic                flashReq,
  input  wire jfa_pkg::jfa_flash_t flashOp,
  output logic                     flashAck,
  output logic [7:0]               flashRdata,
  output logic                     flashFail,
  // Bench controls and observation
  input  wire logic [9:0]          lat,
  output int                       nOps,
  output jfa_pkg::jfa_flash_t      lastOp
);
  // Address that behaves as a locked location
  localparam logic [15:0] LOCK_ADDR = 16'h0bad;
  logic [7:0] mem [logic [15:0]];
  int         cnt;
  // Counts each request, answers after lat+1 cycles, scrambles idle outputs
  always @(posedge sys_clk) begin
    flashAck <= 1'b0;
    flashRdata <= ~flashRdata;
    flashFail <= ~flashFail;
    if (rst) begin
      cnt <= 0;
      nOps <= 0;
      flashRdata <= 8'h00;
      flashFail <= 1'b0;
      lastOp <= '0;
    end else if (flashReq && !flashAck) begin
      if (cnt == 0) begin
        nOps <= nOps + 1;
        lastOp <= flashOp;
      end
      if (cnt >= int'(lat)) begin
        cnt <= 0;
        flashAck <= 1'b1;
        flashFail <= (flashOp.addr == LOCK_ADDR);
        flashRdata <= mem.exists(flashOp.addr) ? mem[flashOp.addr] : 8'hff;
        if (flashOp.cmd == jfa_pkg::FC_PROG) begin
          mem[flashOp.addr] = flashOp.wdata;
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
